// ==== src/gpio_bcd_defs.vh ====
// Register offsets, field positions and reset values for the port B/C/D block
`ifndef GPIO_BCD_DEFS_VH
`define GPIO_BCD_DEFS_VH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define ADDR_B_DATA      8'h06
`define ADDR_C_DATA      8'h07
`define ADDR_D_DATA      8'h08
`define ADDR_OPTION      8'h81
`define ADDR_B_DIR       8'h86
`define ADDR_C_DIR       8'h87
`define ADDR_D_DIR       8'h88
`define ADDR_E_DIR       8'h89
`define ADDR_IRQ_CTRL    8'h0B

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OPT_PULLUP_DIS   7
`define OPT_EDGE_SEL     6
`define E_SLAVE_MODE     4
`define IRQ_CHANGE_FLAG  0
`define IRQ_EXT_FLAG     1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_DIR          8'hFF
`define RST_OPTION       8'hFF
`define RST_E_DIR        8'h07
`define RST_DATA         8'h00

`endif

// ==== src/gpio_ports_b_c_d.v ====
// General purpose I/O ports B, C and D with register access
`timescale 1ns/100ps
`include "gpio_bcd_defs.vh"

module gpio_ports_b_c_d #(
    parameter HAS_PORT_D = 1
) (
    input  wire       i_sys_clk,
    input  wire       i_rst_n,
    input  wire       i_por_n,
    input  wire [7:0] i_addr,
    input  wire [7:0] i_wdata,
    input  wire       i_wr,
    input  wire       i_rd,
    output reg  [7:0] o_rdata,
    input  wire [7:0] i_pin_b,
    output reg  [7:0] o_pin_b,
    output reg  [7:0] o_pin_b_oe_n,
    output reg  [7:0] o_pin_b_pullup,
    input  wire [7:0] i_pin_c,
    output reg  [7:0] o_pin_c,
    output reg  [7:0] o_pin_c_oe_n,
    input  wire [7:0] i_pin_d,
    output reg  [7:0] o_pin_d,
    output reg  [7:0] o_pin_d_oe_n,
    input  wire       i_prog_mode,
    input  wire       i_prog_data_out,
    input  wire       i_prog_data_oe,
    output reg        o_prog_clk,
    output reg        o_prog_data,
    input  wire [7:0] i_periph_c_en,
    input  wire [7:0] i_periph_c_out_en,
    input  wire [7:0] i_periph_c_out,
    output reg  [7:0] o_periph_c_in,
    input  wire       i_slave_drive,
    input  wire       i_slave_latch,
    output reg  [7:0] o_slave_data_in,
    output reg        o_slave_mode,
    output reg        o_ext_irq_edge,
    output reg        o_ext_irq_pin,
    output reg        o_change_irq
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg  [7:0] b_data_q;
    reg  [7:0] c_data_q;
    reg  [7:0] d_data_q;
    reg  [7:0] b_dir_q;
    reg  [7:0] c_dir_q;
    reg  [7:0] d_dir_q;
    reg  [7:0] e_dir_q;
    reg  [7:0] option_q;
    reg  [7:0] b_last_read_q;
    reg        change_flag_q;
    reg        ext_flag_q;
    reg        ext_pin_prev_q;
    reg  [7:0] rdata_d;

    wire       wr_b   = i_wr && (i_addr == `ADDR_B_DATA);
    wire       rd_b   = i_rd && (i_addr == `ADDR_B_DATA);
    wire       wr_irq = i_wr && (i_addr == `ADDR_IRQ_CTRL);
    wire       slave_mode = (HAS_PORT_D != 0) && e_dir_q[`E_SLAVE_MODE];

    // Effective port C direction; peripheral overrides win
    wire [7:0] c_dir_eff = (i_periph_c_en & ~i_periph_c_out_en) |
                           (~i_periph_c_en & c_dir_q);

    // Mismatch only on input-configured upper pins
    wire [3:0] mismatch  = (i_pin_b[7:4] ^ b_last_read_q[7:4]) & b_dir_q[7:4];
    wire       change_ev = |mismatch;

    // External interrupt edge: option bit 6 set selects rising
    wire       ext_ev = option_q[`OPT_EDGE_SEL] ? (i_pin_b[0] & ~ext_pin_prev_q)
                                                : (~i_pin_b[0] & ext_pin_prev_q);

    // Port B enables as they will be driven; pull-ups follow these, not the raw
    // direction, so programming mode cannot leave a pull-up on a driven pin
    wire [7:0] b_oe_n_d = i_prog_mode ? {~i_prog_data_oe, 1'b1, b_dir_q[5:0]}
                                      : b_dir_q;

    // ----------------------------------------------------------------
    // Data latches
    // Survive warm resets; only power-on clears them
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (!i_por_n) begin
            b_data_q <= `RST_DATA;
            c_data_q <= `RST_DATA;
            d_data_q <= `RST_DATA;
        end else begin
            if (wr_b) begin
                b_data_q <= i_wdata;
            end
            if (i_wr && (i_addr == `ADDR_C_DATA)) begin
                c_data_q <= i_wdata;
            end
            if (HAS_PORT_D != 0) begin
                if (slave_mode && i_slave_latch) begin
                    d_data_q <= i_pin_d;
                end else if (i_wr && (i_addr == `ADDR_D_DATA)) begin
                    d_data_q <= i_wdata;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (!i_rst_n || !i_por_n) begin
            b_dir_q        <= `RST_DIR;
            c_dir_q        <= `RST_DIR;
            d_dir_q        <= `RST_DIR;
            e_dir_q        <= `RST_E_DIR;
            option_q       <= `RST_OPTION;
            b_last_read_q  <= 8'h00;
            change_flag_q  <= 1'b0;
            ext_flag_q     <= 1'b0;
            // Idle level of a pulled-up pin; avoids a false rising edge after reset
            ext_pin_prev_q <= 1'b1;
        end else begin
            if (i_wr && (i_addr == `ADDR_B_DIR)) begin
                b_dir_q <= i_wdata;
            end
            if (i_wr && (i_addr == `ADDR_C_DIR)) begin
                c_dir_q <= i_wdata;
            end
            if ((HAS_PORT_D != 0) && i_wr && (i_addr == `ADDR_D_DIR)) begin
                d_dir_q <= i_wdata;
            end
            if ((HAS_PORT_D != 0) && i_wr && (i_addr == `ADDR_E_DIR)) begin
                e_dir_q <= {3'h0, i_wdata[4], 1'b0, i_wdata[2:0]};
            end
            if (i_wr && (i_addr == `ADDR_OPTION)) begin
                option_q <= i_wdata;
            end
            // Any port B access ends the mismatch by latching the pins
            if (rd_b || wr_b) begin
                b_last_read_q <= i_pin_b;
            end
            ext_pin_prev_q <= i_pin_b[0];
            // Set wins over a software clear in the same cycle
            if (change_ev) begin
                change_flag_q <= 1'b1;
            end else if (wr_irq) begin
                change_flag_q <= i_wdata[`IRQ_CHANGE_FLAG];
            end
            if (ext_ev) begin
                ext_flag_q <= 1'b1;
            end else if (wr_irq) begin
                ext_flag_q <= i_wdata[`IRQ_EXT_FLAG];
            end
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    always @* begin
        case (i_addr)
            `ADDR_B_DATA:   rdata_d = i_pin_b;
            `ADDR_C_DATA:   rdata_d = i_pin_c;
            `ADDR_D_DATA:   rdata_d = (HAS_PORT_D != 0) ? i_pin_d : 8'h00;
            `ADDR_OPTION:   rdata_d = option_q;
            `ADDR_B_DIR:    rdata_d = b_dir_q;
            `ADDR_C_DIR:    rdata_d = c_dir_q;
            `ADDR_D_DIR:    rdata_d = (HAS_PORT_D != 0) ? d_dir_q : 8'h00;
            `ADDR_E_DIR:    rdata_d = (HAS_PORT_D != 0) ? e_dir_q : 8'h00;
            `ADDR_IRQ_CTRL: rdata_d = {6'h00, ext_flag_q, change_flag_q};
            default:        rdata_d = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // Pin drivers, all registered
    // ----------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (!i_rst_n || !i_por_n) begin
            o_rdata         <= 8'h00;
            o_pin_b         <= 8'h00;
            o_pin_b_oe_n    <= 8'hFF;
            o_pin_b_pullup  <= 8'h00;
            o_pin_c         <= 8'h00;
            o_pin_c_oe_n    <= 8'hFF;
            o_pin_d         <= 8'h00;
            o_pin_d_oe_n    <= 8'hFF;
            o_prog_clk      <= 1'b0;
            o_prog_data     <= 1'b0;
            o_periph_c_in   <= 8'h00;
            o_slave_data_in <= 8'h00;
            o_slave_mode    <= 1'b0;
            o_ext_irq_edge  <= 1'b1;
            o_ext_irq_pin   <= 1'b0;
            o_change_irq    <= 1'b0;
        end else begin
            o_rdata <= i_rd ? rdata_d : 8'h00;
            // Programming mode takes pins 6/7; pin 7 driven only when asked
            if (i_prog_mode) begin
                o_pin_b      <= {i_prog_data_out, b_data_q[6:0]};
            end else begin
                o_pin_b      <= b_data_q;
            end
            o_pin_b_oe_n   <= b_oe_n_d;
            o_pin_b_pullup <= b_oe_n_d & {8{~option_q[`OPT_PULLUP_DIS]}};
            o_prog_clk     <= i_prog_mode & i_pin_b[6];
            o_prog_data    <= i_prog_mode & i_pin_b[7];
            // Peripheral value replaces the latch on overridden outputs
            o_pin_c        <= (i_periph_c_en & i_periph_c_out) |
                              (~i_periph_c_en & c_data_q);
            o_pin_c_oe_n   <= c_dir_eff;
            o_periph_c_in  <= i_pin_c & i_periph_c_en;
            o_pin_d        <= (HAS_PORT_D != 0) ? d_data_q : 8'h00;
            if (HAS_PORT_D == 0) begin
                o_pin_d_oe_n <= 8'hFF;
            end else if (slave_mode) begin
                o_pin_d_oe_n <= {8{~i_slave_drive}};
            end else begin
                o_pin_d_oe_n <= d_dir_q;
            end
            o_slave_data_in <= slave_mode ? i_pin_d : 8'h00;
            o_slave_mode    <= slave_mode;
            o_ext_irq_edge  <= option_q[`OPT_EDGE_SEL];
            o_ext_irq_pin   <= ext_flag_q;
            o_change_irq    <= change_flag_q;
        end
    end

endmodule

// ==== test/gpio_bcd_monitor.sv ====
// Concurrent checks on the port B/C/D block ports
`timescale 1ns/100ps
module gpio_bcd_monitor (
    input wire logic       i_sys_clk,
    input wire logic       i_rst_n,
    input wire logic       i_por_n,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [7:0] i_pin_b,
    input wire logic [7:0] i_pin_c,
    input wire logic [7:0] o_pin_b_oe_n,
    input wire logic [7:0] o_pin_b_pullup,
    input wire logic [7:0] o_pin_c_oe_n,
    input wire logic [7:0] i_periph_c_en,
    input wire logic       o_ext_irq_edge,
    input wire logic       o_slave_mode
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n || !i_por_n);
    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not zero outside a read");
    chk_read_b: assert property (i_rd && i_addr == 8'h06 |=> o_rdata == $past(i_pin_b))
        else $error("port B read is not the pin level");
    chk_read_c: assert property (i_rd && i_addr == 8'h07 |=> o_rdata == $past(i_pin_c))
        else $error("port C read is not the pin level");
    chk_b_dir: assert property (i_wr && i_addr == 8'h86 |-> ##2 o_pin_b_oe_n == $past(i_wdata, 2))
        else $error("port B enables do not follow direction");
    chk_c_dir: assert property (i_wr && i_addr == 8'h87 && i_periph_c_en == 8'h00 ##1
        i_periph_c_en == 8'h00 |-> ##1 o_pin_c_oe_n == $past(i_wdata, 2))
        else $error("port C enables do not follow direction");
    chk_pullup_out: assert property ((o_pin_b_pullup & ~o_pin_b_oe_n) == 8'h00)
        else $error("pull-up on a driven pin");
    chk_pullup_off: assert property (i_wr && i_addr == 8'h81 && i_wdata[7] ##1
        !(i_wr && i_addr == 8'h81) |-> ##1 o_pin_b_pullup == 8'h00)
        else $error("pull-ups stay on while disabled");
    chk_edge_sel: assert property (i_wr && i_addr == 8'h81 |-> ##2 o_ext_irq_edge == $past(i_wdata[6], 2))
        else $error("edge select does not follow option");
    chk_slave_sel: assert property (i_wr && i_addr == 8'h89 |-> ##2 o_slave_mode == $past(i_wdata[4], 2))
        else $error("slave mode does not follow control bit");
endmodule
bind gpio_ports_b_c_d gpio_bcd_monitor u_mon (.i_sys_clk, .i_rst_n, .i_por_n, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_pin_b, .i_pin_c, .o_pin_b_oe_n, .o_pin_b_pullup, .o_pin_c_oe_n,
    .i_periph_c_en, .o_ext_irq_edge, .o_slave_mode);

// ==== test/tb_top.sv ====
// Self-checking testbench for the port B/C/D block
`timescale 1ns/100ps
`include "gpio_bcd_defs.vh"
module tb_top;
    logic        i_sys_clk = 1'b0, i_rst_n = 1'b0, i_por_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic [7:0]  i_addr = 8'h00, i_wdata = 8'h00, i_pin_b = 8'h00, i_pin_c = 8'h00, i_pin_d = 8'h00;
    logic        i_prog_mode = 1'b0, i_prog_data_out = 1'b0, i_prog_data_oe = 1'b0;
    logic        i_slave_drive = 1'b0, i_slave_latch = 1'b0;
    logic [7:0]  i_periph_c_en = 8'h00, i_periph_c_out_en = 8'h00, i_periph_c_out = 8'h00;
    wire  [7:0]  o_rdata, o_pin_b, o_pin_b_oe_n, o_pin_b_pullup, o_pin_c, o_pin_c_oe_n;
    wire  [7:0]  o_pin_d, o_pin_d_oe_n, o_periph_c_in, o_slave_data_in;
    wire         o_prog_clk, o_prog_data, o_slave_mode, o_ext_irq_edge, o_ext_irq_pin, o_change_irq;
    int          fail_count = 0, num_checks = 0;
    logic [31:0] seed = 32'hA038FAA2;
    logic [7:0]  m [256];
    logic [7:0]  cfg [5] = '{8'h81, 8'h86, 8'h87, 8'h88, 8'h89};
    logic [7:0]  r, e;
    gpio_ports_b_c_d #(.HAS_PORT_D(1)) i_gpio_ports_b_c_d (.i_sys_clk, .i_rst_n, .i_por_n,
        .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pin_b, .o_pin_b, .o_pin_b_oe_n,
        .o_pin_b_pullup, .i_pin_c, .o_pin_c, .o_pin_c_oe_n, .i_pin_d, .o_pin_d, .o_pin_d_oe_n,
        .i_prog_mode, .i_prog_data_out, .i_prog_data_oe, .o_prog_clk, .o_prog_data,
        .i_periph_c_en, .i_periph_c_out_en, .i_periph_c_out, .o_periph_c_in, .i_slave_drive,
        .i_slave_latch, .o_slave_data_in, .o_slave_mode, .o_ext_irq_edge, .o_ext_irq_pin,
        .o_change_irq);
    initial forever #12.5 i_sys_clk = ~i_sys_clk;
    // ----------------------------------------------------------------
    // Bus tasks and reference model
    // ----------------------------------------------------------------
    function automatic logic [7:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t: saw %h expected %h", $time, got, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask
    // Model keeps only configuration; data latches survive a plain reset
    task automatic rst_model();
        foreach (cfg[k]) m[cfg[k]] = 8'hFF;
        m[`ADDR_E_DIR] = `RST_E_DIR;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        m[a] = (a == `ADDR_E_DIR) ? (d & 8'h17) : d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] x);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rdata, x);
    endtask
    task automatic pins_b(input logic [7:0] v);
        @(posedge i_sys_clk);
        i_pin_b <= v;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        fail_count++;
        tally_and_finish();
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        rst_model();
        m[`ADDR_B_DATA] = `RST_DATA;
        m[`ADDR_C_DATA] = `RST_DATA;
        m[`ADDR_D_DATA] = `RST_DATA;
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        i_por_n <= 1'b1;
        step(2);
        chk(o_pin_b_pullup, 8'h00);
        chk(o_pin_c_oe_n, 8'hFF);
        foreach (cfg[k]) rd(cfg[k], m[cfg[k]]);
        foreach (cfg[k]) begin
            wr(cfg[k], rnd());
            rd(cfg[k], m[cfg[k]]);
        end
        wr(`ADDR_B_DIR, rnd());
        wr(`ADDR_OPTION, 8'h40);
        wr(`ADDR_B_DATA, rnd());
        step(2);
        chk(o_pin_b_oe_n, m[`ADDR_B_DIR]);
        chk(o_pin_b_pullup, m[`ADDR_B_DIR]);
        chk(o_pin_b, m[`ADDR_B_DATA]);
        chk({7'h00, o_ext_irq_edge}, 8'h01);
        wr(`ADDR_OPTION, 8'hC0);
        step(2);
        chk(o_pin_b_pullup, 8'h00);
        r = rnd();
        pins_b(r);
        rd(`ADDR_B_DATA, r);
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rst_model();
        step(2);
        chk(o_pin_b, m[`ADDR_B_DATA]);
        chk(o_pin_b_oe_n, 8'hFF);
        repeat (4) begin
            @(posedge i_sys_clk);
            i_periph_c_en <= 8'h00;
            wr(`ADDR_C_DIR, rnd());
            wr(`ADDR_C_DATA, rnd());
            @(posedge i_sys_clk);
            i_periph_c_en <= rnd();
            i_periph_c_out_en <= rnd();
            i_periph_c_out <= rnd();
            i_pin_c <= rnd();
            step(3);
            e = i_periph_c_en;
            chk(o_pin_c_oe_n, (e & ~i_periph_c_out_en) | (~e & m[`ADDR_C_DIR]));
            chk(o_pin_c, (e & i_periph_c_out) | (~e & m[`ADDR_C_DATA]));
            chk(o_periph_c_in, i_pin_c & e);
            rd(`ADDR_C_DATA, i_pin_c);
        end
        wr(`ADDR_D_DIR, rnd());
        wr(`ADDR_D_DATA, rnd());
        @(posedge i_sys_clk);
        i_pin_d <= rnd();
        step(2);
        chk(o_pin_d_oe_n, m[`ADDR_D_DIR]);
        chk(o_pin_d, m[`ADDR_D_DATA]);
        rd(`ADDR_D_DATA, i_pin_d);
        wr(`ADDR_E_DIR, 8'h17);
        r = rnd();
        @(posedge i_sys_clk);
        i_pin_d <= r;
        i_slave_latch <= 1'b1;
        @(posedge i_sys_clk);
        i_slave_latch <= 1'b0;
        step(2);
        chk({7'h00, o_slave_mode}, 8'h01);
        chk(o_slave_data_in, r);
        wr(`ADDR_E_DIR, 8'h07);
        wr(`ADDR_B_DIR, 8'hEF);
        pins_b(8'h00);
        rd(`ADDR_B_DATA, 8'h00);
        wr(`ADDR_IRQ_CTRL, 8'h00);
        pins_b(8'h18);
        step(3);
        chk({7'h00, o_change_irq}, 8'h00);
        pins_b(8'h98);
        step(3);
        chk({7'h00, o_change_irq}, 8'h01);
        rd(`ADDR_IRQ_CTRL, 8'h01);
        rd(`ADDR_B_DATA, 8'h98);
        wr(`ADDR_IRQ_CTRL, 8'h00);
        pins_b(8'h99);
        step(3);
        chk({6'h00, o_ext_irq_pin, o_change_irq}, 8'h02);
        wr(`ADDR_IRQ_CTRL, 8'h00);
        pins_b(8'h98);
        step(3);
        chk({7'h00, o_ext_irq_pin}, 8'h00);
        @(posedge i_sys_clk);
        i_prog_mode <= 1'b1;
        i_pin_b <= 8'h40;
        step(3);
        chk({6'h00, o_prog_clk, o_prog_data}, 8'h02);
        tally_and_finish();
    end
endmodule
